/* asbl_host.sv */
/*
 * Host controller for an asynchronous 512K x 16 static memory with two
 * chip selects, write strobe, output enable and two byte-lane enables.
 * Assumes the supply is stable when RST is released and that the data
 * pins are resolved outside from DQ_O and DQ_OE.
 */
`timescale 1ns/100ps

module asbl_host
    import asbl_pkg::*;
#(
    parameter int PWRUP_CYC = PWRUP_CYC_DEF
)(
    input  wire logic              CORE_CLK,
    input  wire logic              RST,
    input  wire logic              REQ_VALID,
    input  wire logic              REQ_WRITE,
    input  wire logic [ADDR_W-1:0] REQ_ADDR,
    input  wire logic [LANES-1:0]  REQ_LANES,
    input  wire logic [DATA_W-1:0] REQ_WDATA,
    output logic                   REQ_READY,
    output logic                   RSP_VALID,
    output logic [DATA_W-1:0]      RSP_RDATA,
    input  wire logic              RET_REQ,
    output logic                   RET_OK,
    output logic [ADDR_W-1:0]      MEM_ADDR,
    output logic                   PRIMARY_SELECT_N,
    output logic                   SECONDARY_SELECT,
    output logic                   WRITE_STROBE_N,
    output logic                   OUTPUT_DRIVE_N,
    output logic                   UPPER_BYTE_LANE_N,
    output logic                   LOWER_BYTE_LANE_N,
    output logic                   WIDTH_STRAP,
    input  wire logic [DATA_W-1:0] DQ_I,
    output logic [DATA_W-1:0]      DQ_O,
    output logic                   DQ_OE
);

    ////////////////////////////////////////////////////////////////////////

    asbl_top_st_t      r;
    asbl_top_st_t      n;
    logic              tmr_load;
    logic [TMR_W-1:0]  tmr_value;
    logic [DATA_W-1:0] rd_masked;

    asbl_tmr_if tmr ();

    asbl_timer asbl_timer_inst (
        .clk (CORE_CLK),
        .rst (RST),
        .t   (tmr.tmr)
    );

    assign tmr.load  = tmr_load;
    assign tmr.value = tmr_value;

    // Lanes that were not enabled read as zero, since the memory leaves
    // those pins floating.
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign rd_masked[g*8 +: 8] = r.lb_n == 1'b0 && g == 0 ||
                                         r.ub_n == 1'b0 && g == 1
                                         ? DQ_I[g*8 +: 8] : 8'h00;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        n           = r;
        n.rsp_valid = 1'b0;
        tmr_load    = 1'b0;
        tmr_value   = '0;
        if (r.up_cnt != TMR_W'(PWRUP_CYC)) begin
            n.up_cnt = r.up_cnt + 1'b1;
        end
        case (r.state)
            ST_PWR_LOAD: begin
                tmr_load  = 1'b1;
                tmr_value = TMR_W'(PWRUP_CYC - 1);
                n.state   = ST_PWR_WAIT;
            end
            ST_PWR_WAIT: begin
                if (tmr.done) begin
                    n.state     = ST_IDLE;
                    n.req_ready = 1'b1;
                end
            end
            ST_IDLE: begin
                if (RET_REQ) begin
                    // Pins are already deselected here, so retention
                    // may be granted at once.
                    n.state     = ST_RET;
                    n.req_ready = 1'b0;
                    n.ret_ok    = 1'b1;
                end else if (REQ_VALID) begin
                    n.req_ready = 1'b0;
                    n.addr      = REQ_ADDR;
                    n.sel1_n    = 1'b0;
                    n.sel2      = 1'b1;
                    n.ub_n      = ~REQ_LANES[1];
                    n.lb_n      = ~REQ_LANES[0];
                    tmr_load    = 1'b1;
                    if (REQ_WRITE) begin
                        n.we_n    = 1'b0;
                        n.dq_o    = REQ_WDATA;
                        n.dq_oe   = 1'b1;
                        tmr_value = TMR_W'(WR_CYC - 1);
                        n.state   = ST_WR;
                    end else begin
                        n.oe_n    = 1'b0;
                        tmr_value = TMR_W'(RD_CYC - 1);
                        n.state   = ST_RD;
                    end
                end
            end
            ST_RD: begin
                if (tmr.done) begin
                    n.rdata     = rd_masked;
                    n.rsp_valid = 1'b1;
                    n.oe_n      = 1'b1;
                    n.sel1_n    = 1'b1;
                    n.sel2      = 1'b0;
                    n.ub_n      = 1'b1;
                    n.lb_n      = 1'b1;
                    n.req_ready = 1'b1;
                    n.state     = ST_IDLE;
                end
            end
            ST_WR: begin
                // The strobe rises first; address, selects and data stay
                // one more cycle so the write ends on the strobe edge.
                if (tmr.done) begin
                    n.we_n  = 1'b1;
                    n.state = ST_WR_HOLD;
                end
            end
            ST_WR_HOLD: begin
                n.dq_oe     = 1'b0;
                n.sel1_n    = 1'b1;
                n.sel2      = 1'b0;
                n.ub_n      = 1'b1;
                n.lb_n      = 1'b1;
                n.rsp_valid = 1'b1;
                n.req_ready = 1'b1;
                n.state     = ST_IDLE;
            end
            ST_RET: begin
                if (!RET_REQ) begin
                    n.ret_ok  = 1'b0;
                    tmr_load  = 1'b1;
                    tmr_value = TMR_W'(REC_CYC - 1);
                    n.state   = ST_PWR_WAIT;
                end
            end
            default: begin
                n = TOP_RST;
            end
        endcase
        n.strap = 1'b1;
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            r <= TOP_RST;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign REQ_READY         = r.req_ready;
    assign RSP_VALID         = r.rsp_valid;
    assign RSP_RDATA         = r.rdata;
    assign RET_OK            = r.ret_ok;
    assign MEM_ADDR          = r.addr;
    assign PRIMARY_SELECT_N  = r.sel1_n;
    assign SECONDARY_SELECT  = r.sel2;
    assign WRITE_STROBE_N    = r.we_n;
    assign OUTPUT_DRIVE_N    = r.oe_n;
    assign UPPER_BYTE_LANE_N = r.ub_n;
    assign LOWER_BYTE_LANE_N = r.lb_n;
    assign WIDTH_STRAP       = r.strap;
    assign DQ_O              = r.dq_o;
    assign DQ_OE             = r.dq_oe;

    ////////////////////////////////////////////////////////////////////////

    AST_WR_SELECTED: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !WRITE_STROBE_N |-> !PRIMARY_SELECT_N && SECONDARY_SELECT && DQ_OE)
        else $error("write strobe low without both selects active");

    AST_WR_PULSE: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N [*2] ##1
        (WRITE_STROBE_N && !PRIMARY_SELECT_N) ##1 PRIMARY_SELECT_N)
        else $error("write strobe pulse or hold cycle has wrong length");

    AST_RD_LEVELS: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !OUTPUT_DRIVE_N |-> WRITE_STROBE_N && !DQ_OE &&
        !PRIMARY_SELECT_N && SECONDARY_SELECT)
        else $error("output enable low outside a proper read");

    AST_RD_ANSWER: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $fell(OUTPUT_DRIVE_N) |-> !OUTPUT_DRIVE_N [*2] ##1
        (OUTPUT_DRIVE_N && RSP_VALID))
        else $error("read answer not given two cycles after enable");

    AST_STRAP_HIGH: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !PRIMARY_SELECT_N |-> WIDTH_STRAP)
        else $error("access made with width strap low");

    AST_PWRUP_WAIT: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !PRIMARY_SELECT_N |-> r.up_cnt == TMR_W'(PWRUP_CYC))
        else $error("access started before power-up wait elapsed");

    AST_RET_DESEL: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        RET_OK |-> PRIMARY_SELECT_N && !SECONDARY_SELECT &&
        $past(PRIMARY_SELECT_N))
        else $error("retention granted while chip selected");

    AST_RET_EXIT: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        $fell(RET_OK) |-> PRIMARY_SELECT_N [*3])
        else $error("access resumed before recovery time");

endmodule

/* asbl_pkg.sv */
/*
 * Shared constants and types for the asynchronous static memory host port.
 * Assumes a single 25 MHz core clock; all pin timing is counted in cycles.
 */
package asbl_pkg;

    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int LANES  = 2;
    localparam int TMR_W  = 13;

    localparam int CLK_PERIOD_NS = 40;
    localparam int T_RC_NS       = 45;
    localparam int T_WC_NS       = 45;
    localparam int T_RECOV_NS    = 45;
    localparam int T_PWRUP_US    = 200;

    // Least times round up to whole cycles.
    localparam int RD_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_CYC = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_CYC = (T_RECOV_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
    localparam int PWRUP_CYC_DEF = (T_PWRUP_US * 1000 + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

    localparam logic PIN_SEL1_N_RST = 1'b1;
    localparam logic PIN_SEL2_RST   = 1'b0;
    localparam logic PIN_WE_N_RST   = 1'b1;
    localparam logic PIN_OE_N_RST   = 1'b1;
    localparam logic PIN_LANE_N_RST = 1'b1;
    localparam logic PIN_STRAP_RST  = 1'b1;

    typedef enum logic [2:0] {
        ST_PWR_LOAD,
        ST_PWR_WAIT,
        ST_IDLE,
        ST_RD,
        ST_WR,
        ST_WR_HOLD,
        ST_RET
    } asbl_state_t;

    typedef struct packed {
        asbl_state_t          state;
        logic [ADDR_W-1:0]    addr;
        logic                 sel1_n;
        logic                 sel2;
        logic                 we_n;
        logic                 oe_n;
        logic                 ub_n;
        logic                 lb_n;
        logic [DATA_W-1:0]    dq_o;
        logic                 dq_oe;
        logic                 strap;
        logic                 req_ready;
        logic                 rsp_valid;
        logic [DATA_W-1:0]    rdata;
        logic                 ret_ok;
        logic [TMR_W-1:0]     up_cnt;
    } asbl_top_st_t;

    localparam asbl_top_st_t TOP_RST = '{
        state:     ST_PWR_LOAD,
        addr:      19'h0_0000,
        sel1_n:    PIN_SEL1_N_RST,
        sel2:      PIN_SEL2_RST,
        we_n:      PIN_WE_N_RST,
        oe_n:      PIN_OE_N_RST,
        ub_n:      PIN_LANE_N_RST,
        lb_n:      PIN_LANE_N_RST,
        dq_o:      16'h0000,
        dq_oe:     1'b0,
        strap:     PIN_STRAP_RST,
        req_ready: 1'b0,
        rsp_valid: 1'b0,
        rdata:     16'h0000,
        ret_ok:    1'b0,
        up_cnt:    13'h0000
    };

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } asbl_tmr_st_t;

endpackage

/* asbl_tmr_if.sv */
/*
 * Load/done link between the port sequencer and its countdown timer.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/100ps
interface asbl_tmr_if;
    import asbl_pkg::*;
    logic             load;
    logic [TMR_W-1:0] value;
    logic             done;
    modport ctl (output load, output value, input done);
    modport tmr (input load, input value, output done);
endinterface

/* asbl_timer.sv */
/*
 * Countdown timer: a load sets the count, done shows when it reaches zero.
 * Assumes load and value come from logic on the same clock.
 */
`timescale 1ns/100ps
module asbl_timer
    import asbl_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    asbl_tmr_if.tmr    t
);
    asbl_tmr_st_t r;
    asbl_tmr_st_t n;

    always_comb begin
        n = r;
        if (t.load) begin
            n.cnt = t.value;
        end else if (r.cnt != '0) begin
            n.cnt = r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign t.done = (r.cnt == '0);
endmodule

/* asbl_sram_model.sv */
/*
 * Behavioural 512K x 16 static memory that stands on the far side of the
 * host port. Assumes the bench resolves the shared data pins.
 */
`timescale 1ns/100ps
module asbl_sram_model
    import asbl_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              sel1_n,
    input  wire logic              sel2,
    input  wire logic              we_n,
    input  wire logic              oe_n,
    input  wire logic              ub_n,
    input  wire logic              lb_n,
    input  wire logic              strap,
    input  wire logic              host_oe,
    input  wire logic [DATA_W-1:0] dq,
    output logic [DATA_W-1:0]      q,
    output logic [LANES-1:0]       q_en,
    output logic                   fault
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic              sel;
    logic              stby;
    logic              wr;
    logic              rd;

    assign sel  = !sel1_n && sel2;
    assign stby = !sel || (ub_n && lb_n);
    assign wr   = sel && !we_n;
    assign rd   = sel && !oe_n && we_n;
    assign q_en = (rd && !stby) ? {!ub_n, !lb_n} : 2'b00;
    assign q    = mem[addr];

    initial fault = 1'b0;

    // Data is latched as the write ends, so set-up is taken at its latest.
    always @(negedge wr) begin
        if (!$isunknown(addr) && !lb_n) mem[addr][7:0] = dq[7:0];
        if (!$isunknown(addr) && !ub_n) mem[addr][15:8] = dq[15:8];
    end

    // Bus fights and byte-wide strapping while selected mark the host wrong.
    always @(host_oe, q_en, sel, strap)
        if ((host_oe && q_en != 2'b00) || (sel && strap !== 1'b1))
            fault = 1'b1;
endmodule

/* asbl_host_tb.sv */
/*
 * Self-checking bench for the static memory host port.
 * Assumes the partner model in asbl_sram_model.sv.
 */
`timescale 1ns/100ps
module asbl_host_tb
    import asbl_pkg::*;
;
    localparam int PWR = 8;
    logic              CORE_CLK, RST, REQ_VALID, REQ_WRITE, RET_REQ, junk;
    logic [ADDR_W-1:0] REQ_ADDR, MEM_ADDR;
    logic [LANES-1:0]  REQ_LANES, q_en;
    logic [DATA_W-1:0] REQ_WDATA, RSP_RDATA, DQ_O, mq, rd;
    wire  [DATA_W-1:0] DQ_I;
    logic              REQ_READY, RSP_VALID, RET_OK, DQ_OE, WIDTH_STRAP, fault;
    logic              PRIMARY_SELECT_N, SECONDARY_SELECT, WRITE_STROBE_N;
    logic              OUTPUT_DRIVE_N, UPPER_BYTE_LANE_N, LOWER_BYTE_LANE_N;
    int                bad_count, n_compared, cyc;

    asbl_host #(.PWRUP_CYC(PWR)) asbl_host_inst (
        .CORE_CLK(CORE_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
        .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_LANES(REQ_LANES),
        .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
        .RSP_RDATA(RSP_RDATA), .RET_REQ(RET_REQ), .RET_OK(RET_OK),
        .MEM_ADDR(MEM_ADDR), .PRIMARY_SELECT_N(PRIMARY_SELECT_N),
        .SECONDARY_SELECT(SECONDARY_SELECT), .WRITE_STROBE_N(WRITE_STROBE_N),
        .OUTPUT_DRIVE_N(OUTPUT_DRIVE_N), .WIDTH_STRAP(WIDTH_STRAP),
        .UPPER_BYTE_LANE_N(UPPER_BYTE_LANE_N),
        .LOWER_BYTE_LANE_N(LOWER_BYTE_LANE_N), .DQ_I(DQ_I), .DQ_O(DQ_O),
        .DQ_OE(DQ_OE)
    );

    asbl_sram_model asbl_sram_model_inst (
        .addr(MEM_ADDR), .sel1_n(PRIMARY_SELECT_N), .sel2(SECONDARY_SELECT),
        .we_n(WRITE_STROBE_N), .oe_n(OUTPUT_DRIVE_N),
        .ub_n(UPPER_BYTE_LANE_N), .lb_n(LOWER_BYTE_LANE_N),
        .strap(WIDTH_STRAP), .host_oe(DQ_OE), .dq(DQ_I), .q(mq),
        .q_en(q_en), .fault(fault)
    );

    // Undriven lines show a pattern that flips each cycle, so a stale
    // value can never pass for read data.
    for (genvar i = 0; i < LANES; i++) begin : g_ln
        assign DQ_I[8*i+:8] = DQ_OE ? DQ_O[8*i+:8]
                            : q_en[i] ? mq[8*i+:8] : {8{junk}};
    end

    initial begin
        CORE_CLK = 1'b0;
        forever #20 CORE_CLK = ~CORE_CLK;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chkb(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chkw(input string nm, input logic [ADDR_W-1:0] e,
                        input logic [ADDR_W-1:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic results;
        $display("Compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [LANES-1:0] l, input logic [DATA_W-1:0] d);
        int lat;
        lat = w ? 3 : 2;
        while (REQ_READY !== 1'b1) @(posedge CORE_CLK) #1;
        @(posedge CORE_CLK);
        REQ_VALID <= 1'b1;
        REQ_WRITE <= w;
        REQ_ADDR  <= a;
        REQ_LANES <= l;
        REQ_WDATA <= d;
        @(posedge CORE_CLK);
        REQ_VALID <= 1'b0;
        for (int k = 1; k <= lat; k++) begin
            @(posedge CORE_CLK) #1;
            if (k == 1) begin
                chkb("sel", 1'b0,
                     PRIMARY_SELECT_N | ~SECONDARY_SELECT);
                chkb("strobe", !w, WRITE_STROBE_N);
                chkb("dq_oe", w, DQ_OE);
                chkw("lanes", {17'h0, ~l}, {17'h0, UPPER_BYTE_LANE_N,
                     LOWER_BYTE_LANE_N});
                chkw("addr", a, MEM_ADDR);
                if (w) chkw("wdata", {3'h0, d}, {3'h0, DQ_O});
                else chkb("outdrive", 1'b0, OUTPUT_DRIVE_N);
            end
            if (w && k == 2)
                chkb("wr_end", 1'b1, WRITE_STROBE_N & DQ_OE
                     & ~PRIMARY_SELECT_N);
            chkb("rsp", k == lat, RSP_VALID);
        end
        chkb("ready", 1'b1, REQ_READY);
        rd = RSP_RDATA;
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [1:0] l,
                         input logic [DATA_W-1:0] e);
        acc(1'b0, a, l, 16'h0000);
        chkw("rdata", {3'h0, e}, {3'h0, rd});
    endtask

    task automatic t_power;
        repeat (4) @(posedge CORE_CLK);
        #1;
        chkb("rst_sel", 1'b1, PRIMARY_SELECT_N & ~SECONDARY_SELECT);
        chkb("rst_oe", 1'b0, DQ_OE | REQ_READY);
        chkb("strap", 1'b1, WIDTH_STRAP);
        @(posedge CORE_CLK);
        RST <= 1'b0;
        for (int k = 1; k <= PWR + 1; k++) begin
            @(posedge CORE_CLK) #1;
            chkb("pwr_ready", k == PWR + 1, REQ_READY);
            chkb("pwr_sel", 1'b1, PRIMARY_SELECT_N);
        end
    endtask

    task automatic t_lanes;
        logic [ADDR_W-1:0] ad [3] = '{19'h0_0000, 19'h7_FFFF, 19'h2_AAAA};
        foreach (ad[i]) acc(1'b1, ad[i], 2'b11, ad[i][15:0] ^ 16'h1234);
        foreach (ad[i]) begin
            rdchk(ad[i], 2'b11, ad[i][15:0] ^ 16'h1234);
            acc(1'b1, ad[i], 2'b01, 16'hABCD);
            acc(1'b1, ad[i], 2'b10, 16'h5678);
            acc(1'b1, ad[i], 2'b00, 16'hFFFF);
            rdchk(ad[i], 2'b01, 16'h00CD);
            rdchk(ad[i], 2'b10, 16'h5600);
            rdchk(ad[i], 2'b00, 16'h0000);
            rdchk(ad[i], 2'b11, 16'h56CD);
        end
    endtask

    // A pending write must lose to retention and never reach the memory.
    task automatic t_ret;
        @(posedge CORE_CLK);
        RET_REQ   <= 1'b1;
        REQ_VALID <= 1'b1;
        REQ_WRITE <= 1'b1;
        REQ_ADDR  <= 19'h0_0000;
        REQ_LANES <= 2'b11;
        REQ_WDATA <= 16'hDEAD;
        repeat (2) @(posedge CORE_CLK);
        #1;
        chkb("ret_ok", 1'b1, RET_OK);
        repeat (6) begin
            @(posedge CORE_CLK) #1;
            chkb("ret_sel", 1'b1,
                 PRIMARY_SELECT_N | ~SECONDARY_SELECT);
            chkb("ret_busy", 1'b0, RSP_VALID | REQ_READY | DQ_OE);
        end
        @(posedge CORE_CLK);
        REQ_VALID <= 1'b0;
        RET_REQ   <= 1'b0;
        for (int k = 1; k <= 3; k++) begin
            @(posedge CORE_CLK) #1;
            chkb("ret_off", 1'b0, RET_OK);
            chkb("rec_ready", k == 3, REQ_READY);
        end
        rdchk(19'h0_0000, 2'b11, 16'h56CD);
    endtask

    initial begin
        RST       = 1'b1;
        REQ_VALID = 1'b0;
        REQ_WRITE = 1'b0;
        REQ_ADDR  = 19'h0_0000;
        REQ_LANES = 2'b00;
        REQ_WDATA = 16'h0000;
        RET_REQ   = 1'b0;
        junk      = 1'b0;
        t_power();
        t_lanes();
        t_ret();
        chkb("fault", 1'b0, fault);
        results();
    end

    always @(posedge CORE_CLK) junk <= ~junk;
endmodule
